// ===== rtl/fsw_pkg.sv
/*
 package for the frequency select / watchdog recovery control block:
 byte offsets, field positions, reset values, timing constants, the
 fixed frequency table and the structs that carry settings around.
 assumes an smbus slave engine in front that turns bus writes into
 single-byte register writes and samples a registered read byte.
*/
// Summary of operation
// R1: 5-bit code picks one of 32 fixed cpu/pci pairs, same gear constant.
// R2: programmable enable resets to 0; while 0 the code sets frequency.
// R3: with programming off, override 0 uses strap code, 1 uses soft bits.
// R4: with programming on, cpu frequency comes from multiplier, divider, gear.
// R5: with programming on, override picks ratio and gear source the same way.
// R6: writing multiplier or divider starts loading a new cpu frequency.
// R7: host should write multiplier and divider in one smbus operation.
// R8: on expiry switch to recovery; select 0 strap code, 1 recovery values.
// R9: recovery values use strap ratio if override clear, soft bits if set.
// R10: writing recovery multiplier or divider starts loading a new frequency.
// R11: writing arm 0 stops watchdog, reloads count, leaves recovery mode.
// R12: armed watchdog only counts down after a frequency change.
// R13: expiry gives system reset, loads recovery frequency, locks recovery.
// R14: in recovery mode all frequency-changing writes are ignored until disarm.
// R15: expired flag reads 1 after expiry; write 1 clears, write 0 nothing.
// R16: programmable mode covers cpu frequencies from 50 to 248 MHz.
// R17: 5-bit timeout count, unit 150 ms or 2.5 s; flag set at zero.
// R18: reset on expiry only if its enable is 1; own enable after change.
// R19: cpu = gear * (mult+3)/(div+3); that ratio must exceed one.
// R20: system reset held active a fixed parameterised number of cycles.
package fsw_pkg;

	// clock
	localparam int CLK_MHZ = 250;

	// byte offsets
	localparam logic [7:0] ADDR_SOFT_CTRL = 8'h0A;
	localparam logic [7:0] ADDR_CPU_MULT = 8'h0D;
	localparam logic [7:0] ADDR_CPU_DIV = 8'h0E;
	localparam logic [7:0] ADDR_RSVD = 8'h11;
	localparam logic [7:0] ADDR_REC_MULT = 8'h12;
	localparam logic [7:0] ADDR_REC_DIV = 8'h13;
	localparam logic [7:0] ADDR_WDOG = 8'h14;
	localparam logic [7:0] ADDR_RST_CTRL = 8'h15;

	// field positions
	localparam int BIT_OVERRIDE = 5;
	localparam int BIT_PROG_EN = 7;
	localparam int BIT_REC_SEL = 7;
	localparam int BIT_SCALE = 5;
	localparam int BIT_ARM = 6;
	localparam int BIT_EXPIRED = 7;
	localparam int BIT_RST_WD = 0;
	localparam int BIT_RST_FC = 1;
	localparam int BIT_REC_MODE = 4;
	localparam int BIT_RST_PIN = 5;

	// reset values and offsets of the programmable terms
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [8:0] TERM_OFFSET = 9'h003;

	// watchdog time units and reset pulse length
	localparam int UNIT_SHORT_MS = 150;
	localparam int UNIT_LONG_MS = 2500;
	localparam int UNIT_SHORT_CYC = UNIT_SHORT_MS * CLK_MHZ * 1000;
	localparam int UNIT_LONG_CYC = UNIT_LONG_MS * CLK_MHZ * 1000;
	localparam int RST_PULSE_CYC = 16;

	// gear constant, millionths
	localparam logic [27:0] GEAR_MICRO = 28'h2DC6EE5;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} fsw_wr_t;

	typedef struct packed {
		logic prog;
		logic [4:0] code;
		logic [8:0] mult_term;
		logic [8:0] div_term;
	} fsw_setting_t;

	// frequencies in units of 100 kHz
	typedef struct packed {
		logic [11:0] cpu;
		logic [11:0] pci;
	} fsw_pair_t;

	typedef enum logic [1:0] {
		WD_IDLE = 2'b00,
		WD_COUNT = 2'b01,
		WD_LOCKED = 2'b10
	} fsw_wd_state_t;

	function automatic fsw_pair_t freq_pair(input logic [4:0] code);
		case (code)
			5'h00: freq_pair = '{12'h7D0, 12'h14D};
			5'h01: freq_pair = '{12'h76C, 12'h17C};
			5'h02: freq_pair = '{12'h708, 12'h168};
			5'h03: freq_pair = '{12'h6A4, 12'h154};
			5'h04: freq_pair = '{12'h67C, 12'h14C};
			5'h05: freq_pair = '{12'h640, 12'h140};
			5'h06: freq_pair = '{12'h5DC, 12'h177};
			5'h07: freq_pair = '{12'h5AA, 12'h16B};
			5'h08: freq_pair = '{12'h578, 12'h15E};
			5'h09: freq_pair = '{12'h550, 12'h154};
			5'h0A: freq_pair = '{12'h514, 12'h145};
			5'h0B: freq_pair = '{12'h4D8, 12'h136};
			5'h0C: freq_pair = '{12'h2A0, 12'h150};
			5'h0D: freq_pair = '{12'h3F0, 12'h150};
			5'h0E: freq_pair = '{12'h49C, 12'h189};
			5'h0F: freq_pair = '{12'h540, 12'h150};
			5'h10: freq_pair = '{12'h29E, 12'h14F};
			5'h11: freq_pair = '{12'h3ED, 12'h14F};
			5'h12: freq_pair = '{12'h47E, 12'h17F};
			5'h13: freq_pair = '{12'h53C, 12'h14F};
			5'h14: freq_pair = '{12'h29C, 12'h14E};
			5'h15: freq_pair = '{12'h3EA, 12'h14E};
			5'h16: freq_pair = '{12'h44C, 12'h16F};
			5'h17: freq_pair = '{12'h538, 12'h14E};
			5'h18: freq_pair = '{12'h41A, 12'h15E};
			5'h19: freq_pair = '{12'h384, 12'h12C};
			5'h1A: freq_pair = '{12'h352, 12'h11B};
			5'h1B: freq_pair = '{12'h30C, 12'h186};
			5'h1C: freq_pair = '{12'h29A, 12'h14D};
			5'h1D: freq_pair = '{12'h3E8, 12'h14D};
			5'h1E: freq_pair = '{12'h2EE, 12'h177};
			default: freq_pair = '{12'h535, 12'h14D};
		endcase
	endfunction : freq_pair

endpackage : fsw_pkg

// ===== rtl/fsw_freq_ctrl.sv
/*
 frequency select and watchdog recovery control.
 assumes a byte write/read port from an smbus slave engine, strap pins
 that are asynchronous, and an outside pll that follows the settings.
*/
`timescale 1ns/1ps
module fsw_freq_ctrl #(
	parameter int UNIT_SHORT_CYC = fsw_pkg::UNIT_SHORT_CYC,
	parameter int UNIT_LONG_CYC = fsw_pkg::UNIT_LONG_CYC,
	parameter int RST_PULSE_CYC = fsw_pkg::RST_PULSE_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire fsw_pkg::fsw_wr_t reg_wr,
	input wire logic [7:0] reg_rd_addr,
	output logic [7:0] reg_rdata,
	input wire logic [4:0] strap_freq_code,
	input wire logic sys_rst_in,
	output logic sys_rst_out,
	output logic sys_rst_oe_n,
	output fsw_pkg::fsw_setting_t freq_setting,
	output fsw_pkg::fsw_pair_t freq_table_out,
	output logic freq_load,
	output logic recovery_mode
);

	logic [4:0] strap_s1_reg, strap_s2_reg, strap_s3_reg, strap_freq_code_reg;
	logic strap_done_reg;
	logic [2:0] rpin_reg;
	logic rst_pin_level_reg;
	logic [7:0] soft_ctrl_reg, cpu_mult_value, cpu_div_reg, rec_mult_value, rec_div_reg;
	logic [7:0] wdog_reg, rst_ctrl_reg;
	logic watchdog_expired_flag;
	fsw_pkg::fsw_wd_state_t wd_state_reg;
	logic [4:0] wd_count_reg;
	logic [31:0] unit_cnt_reg;
	logic [31:0] rst_cnt_reg;
	logic expire;
	logic change_write;
	logic wr_ok;
	fsw_pkg::fsw_setting_t setting_next;
	logic [4:0] sel_code;

	////////////////////////////////////////////////////////////////////////
	// pin capture

	// strap code: three flops, latched once after reset when stages agree
	always_ff @(posedge clk)
	begin
		strap_s1_reg <= strap_freq_code;
		strap_s2_reg <= strap_s1_reg;
		strap_s3_reg <= strap_s2_reg;
		if (srst)
		begin
			strap_done_reg <= 1'b0;
			strap_freq_code_reg <= 5'h00;
		end
		else if (!strap_done_reg && strap_s2_reg == strap_s3_reg)
		begin
			strap_done_reg <= 1'b1;
			strap_freq_code_reg <= strap_s3_reg;
		end
	end

	// reset pin level readback, same filtering
	always_ff @(posedge clk)
	begin
		rpin_reg <= {rpin_reg[1:0], sys_rst_in};
		if (srst)
			rst_pin_level_reg <= 1'b1;
		else if (rpin_reg[1] == rpin_reg[2])
			rst_pin_level_reg <= rpin_reg[2];
	end

	////////////////////////////////////////////////////////////////////////
	// register writes

	// frequency writes are refused while locked in recovery
	assign wr_ok = reg_wr.wr && !recovery_mode; // R14
	assign change_write = wr_ok && (reg_wr.addr == fsw_pkg::ADDR_CPU_MULT // R6
		|| reg_wr.addr == fsw_pkg::ADDR_CPU_DIV
		|| reg_wr.addr == fsw_pkg::ADDR_REC_MULT // R10
		|| reg_wr.addr == fsw_pkg::ADDR_REC_DIV
		|| reg_wr.addr == fsw_pkg::ADDR_SOFT_CTRL);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			soft_ctrl_reg <= fsw_pkg::BYTE_RESET;
			cpu_mult_value <= fsw_pkg::BYTE_RESET;
			cpu_div_reg <= fsw_pkg::BYTE_RESET; // R2
			rec_mult_value <= fsw_pkg::BYTE_RESET;
			rec_div_reg <= fsw_pkg::BYTE_RESET;
		end
		else if (wr_ok)
		begin
			case (reg_wr.addr)
				fsw_pkg::ADDR_SOFT_CTRL: soft_ctrl_reg <= {2'b00, reg_wr.data[5:0]};
				fsw_pkg::ADDR_CPU_MULT: cpu_mult_value <= reg_wr.data;
				fsw_pkg::ADDR_CPU_DIV: cpu_div_reg <= reg_wr.data;
				fsw_pkg::ADDR_REC_MULT: rec_mult_value <= reg_wr.data;
				fsw_pkg::ADDR_REC_DIV: rec_div_reg <= reg_wr.data;
				default: ;
			endcase
		end
	end

	// watchdog and reset control bytes stay writable in recovery
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wdog_reg <= fsw_pkg::BYTE_RESET;
			rst_ctrl_reg <= fsw_pkg::BYTE_RESET;
		end
		else if (reg_wr.wr)
		begin
			if (reg_wr.addr == fsw_pkg::ADDR_WDOG)
				wdog_reg <= {1'b0, reg_wr.data[6:0]};
			if (reg_wr.addr == fsw_pkg::ADDR_RST_CTRL)
				rst_ctrl_reg <= {6'h00, reg_wr.data[1:0]};
		end
	end

	// expired flag: set beats a same-cycle write-one clear
	always_ff @(posedge clk)
	begin
		if (srst)
			watchdog_expired_flag <= 1'b0;
		else if (expire)
			watchdog_expired_flag <= 1'b1; // R17
		else if (reg_wr.wr && reg_wr.addr == fsw_pkg::ADDR_WDOG
			&& reg_wr.data[fsw_pkg::BIT_EXPIRED])
			watchdog_expired_flag <= 1'b0; // R15
	end

	// registered read port; unmapped and reserved bytes read zero
	always_ff @(posedge clk)
	begin
		if (srst)
			reg_rdata <= fsw_pkg::BYTE_RESET;
		else
		begin
			case (reg_rd_addr)
				fsw_pkg::ADDR_SOFT_CTRL: reg_rdata <= soft_ctrl_reg;
				fsw_pkg::ADDR_CPU_MULT: reg_rdata <= cpu_mult_value;
				fsw_pkg::ADDR_CPU_DIV: reg_rdata <= cpu_div_reg;
				fsw_pkg::ADDR_REC_MULT: reg_rdata <= rec_mult_value;
				fsw_pkg::ADDR_REC_DIV: reg_rdata <= rec_div_reg;
				fsw_pkg::ADDR_WDOG: reg_rdata <= {watchdog_expired_flag, wdog_reg[6:0]}; // R15
				fsw_pkg::ADDR_RST_CTRL: reg_rdata <= {2'b00, rst_pin_level_reg,
					recovery_mode, 2'b00, rst_ctrl_reg[1:0]};
				default: reg_rdata <= fsw_pkg::BYTE_RESET;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frequency selection

	// override picks soft bits over the latched strap code
	assign sel_code = soft_ctrl_reg[fsw_pkg::BIT_OVERRIDE] ?
		soft_ctrl_reg[4:0] : strap_freq_code_reg; // R3 R5 R9

	always_comb
	begin
		setting_next.prog = 1'b0;
		setting_next.code = sel_code; // R1
		setting_next.mult_term = {1'b0, cpu_mult_value} + fsw_pkg::TERM_OFFSET; // R19 R16
		setting_next.div_term = {2'b00, cpu_div_reg[6:0]} + fsw_pkg::TERM_OFFSET;
		if (recovery_mode)
		begin
			if (rec_div_reg[fsw_pkg::BIT_REC_SEL]) // R8
			begin
				setting_next.prog = 1'b1;
				setting_next.mult_term = {1'b0, rec_mult_value} + fsw_pkg::TERM_OFFSET;
				setting_next.div_term = {2'b00, rec_div_reg[6:0]} + fsw_pkg::TERM_OFFSET;
			end
			else
				setting_next.code = strap_freq_code_reg; // R8
		end
		else if (cpu_div_reg[fsw_pkg::BIT_PROG_EN])
			setting_next.prog = 1'b1; // R4
	end

	// a ratio of one or less is never passed on; last good setting holds
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			freq_setting <= '0;
			freq_table_out <= '0;
		end
		else
		begin
			if (!setting_next.prog || setting_next.mult_term > setting_next.div_term) // R19
				freq_setting <= setting_next;
			freq_table_out <= fsw_pkg::freq_pair(freq_setting.code); // R1
		end
	end

	// load strobe on frequency writes and on entry to recovery
	always_ff @(posedge clk)
	begin
		if (srst)
			freq_load <= 1'b0;
		else
			freq_load <= change_write || expire; // R6 R10 R13
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog

	assign expire = wd_state_reg == fsw_pkg::WD_COUNT && wd_count_reg == 5'h00 // R17
		&& unit_cnt_reg == 32'h0000_0000 && wdog_reg[fsw_pkg::BIT_ARM];

	always_ff @(posedge clk)
	begin
		if (srst || !wdog_reg[fsw_pkg::BIT_ARM])
		begin
			wd_state_reg <= fsw_pkg::WD_IDLE; // R11
			wd_count_reg <= wdog_reg[4:0];
			unit_cnt_reg <= 32'h0000_0000;
			recovery_mode <= 1'b0; // R11
		end
		else
		begin
			case (wd_state_reg)
				fsw_pkg::WD_IDLE:
					if (freq_load) // R12
					begin
						wd_state_reg <= fsw_pkg::WD_COUNT;
						wd_count_reg <= wdog_reg[4:0];
						unit_cnt_reg <= wdog_reg[fsw_pkg::BIT_SCALE] ? // R17
							32'(UNIT_LONG_CYC - 1) : 32'(UNIT_SHORT_CYC - 1);
					end
				fsw_pkg::WD_COUNT:
					if (expire)
					begin
						wd_state_reg <= fsw_pkg::WD_LOCKED; // R13
						recovery_mode <= 1'b1;
					end
					else if (unit_cnt_reg != 32'h0000_0000)
						unit_cnt_reg <= unit_cnt_reg - 32'h0000_0001;
					else
					begin
						wd_count_reg <= wd_count_reg - 5'h01;
						unit_cnt_reg <= wdog_reg[fsw_pkg::BIT_SCALE] ?
							32'(UNIT_LONG_CYC - 1) : 32'(UNIT_SHORT_CYC - 1);
					end
				fsw_pkg::WD_LOCKED: ;
				default: wd_state_reg <= fsw_pkg::WD_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system reset pin, open drain: only ever pulls low

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rst_cnt_reg <= 32'h0000_0000;
			sys_rst_oe_n <= 1'b1;
			sys_rst_out <= 1'b0;
		end
		else
		begin
			if ((expire && rst_ctrl_reg[fsw_pkg::BIT_RST_WD]) // R18 R13
				|| (change_write && rst_ctrl_reg[fsw_pkg::BIT_RST_FC]))
				rst_cnt_reg <= 32'(RST_PULSE_CYC); // R20
			else if (rst_cnt_reg != 32'h0000_0000)
				rst_cnt_reg <= rst_cnt_reg - 32'h0000_0001;
			sys_rst_oe_n <= !((expire && rst_ctrl_reg[fsw_pkg::BIT_RST_WD])
				|| (change_write && rst_ctrl_reg[fsw_pkg::BIT_RST_FC])
				|| rst_cnt_reg > 32'h0000_0001);
		end
	end

endmodule : fsw_freq_ctrl

// ===== bench/fsw_freq_ctrl_props.sv
/*
 checker for the frequency select / watchdog recovery control block.
 assumes it is bound to fsw_freq_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module fsw_freq_ctrl_props #(
	parameter int RST_PULSE_CYC = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire fsw_pkg::fsw_wr_t reg_wr,
	input wire logic sys_rst_oe_n,
	input wire fsw_pkg::fsw_setting_t freq_setting,
	input wire logic freq_load,
	input wire logic recovery_mode
);
	logic ovr_reg;
	logic [4:0] soft_reg;
	logic wd_rst_reg;
	int low_cnt_reg;
	logic wr_ok;
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////
	// writes that the block must act on: locked mode refuses most of them
	assign wr_ok = reg_wr.wr && !recovery_mode;
	// shadow of soft select, only accepted writes land
	always_ff @(posedge clk)
	begin
		if (srst)
			{ovr_reg, soft_reg} <= 6'h00;
		else if (wr_ok && reg_wr.addr == fsw_pkg::ADDR_SOFT_CTRL)
			{ovr_reg, soft_reg} <= reg_wr.data[5:0];
	end
	// shadow of reset-on-expiry enable, writable in any mode
	always_ff @(posedge clk)
	begin
		if (srst)
			wd_rst_reg <= 1'b0;
		else if (reg_wr.wr && reg_wr.addr == fsw_pkg::ADDR_RST_CTRL)
			wd_rst_reg <= reg_wr.data[fsw_pkg::BIT_RST_WD];
	end
	// cycles the reset pin has been held low so far
	always_ff @(posedge clk)
	begin
		if (srst || sys_rst_oe_n)
			low_cnt_reg <= 0;
		else
			low_cnt_reg <= low_cnt_reg + 1;
	end

	////////////////////////////////////////////////////////////////////////
	sequence load_pulse;
		freq_load ##1 !freq_load;
	endsequence
	chk_mult_load: assert property (wr_ok && reg_wr.addr == fsw_pkg::ADDR_CPU_MULT
		|=> freq_load) else $error("no load after multiplier write");
	chk_rec_load: assert property (wr_ok && reg_wr.addr == fsw_pkg::ADDR_REC_DIV
		|=> freq_load) else $error("no load after recovery divider write");
	chk_locked_refuse: assert property (recovery_mode && reg_wr.wr && reg_wr.addr inside
		{8'h0A, 8'h0D, 8'h0E, 8'h12, 8'h13} |=> !freq_load) else $error("locked write loaded");
	chk_expiry_load: assert property ($rose(recovery_mode) |-> load_pulse)
		else $error("expiry without single load pulse");
	chk_disarm_exit: assert property (recovery_mode && reg_wr.wr && reg_wr.addr ==
		fsw_pkg::ADDR_WDOG && !reg_wr.data[6] |=> ##1 !recovery_mode)
		else $error("still locked");
	chk_pulse_width: assert property ($rose(sys_rst_oe_n) |-> low_cnt_reg == RST_PULSE_CYC)
		else $error("reset pulse width wrong");
	chk_pulse_cap: assert property (!sys_rst_oe_n |-> low_cnt_reg < RST_PULSE_CYC)
		else $error("reset pulse too long");
	chk_expiry_rst: assert property ($rose(recovery_mode) |-> sys_rst_oe_n == !wd_rst_reg)
		else $error("expiry reset gating wrong");
	chk_soft_code: assert property (freq_load && ovr_reg && !recovery_mode |=>
		freq_setting.prog || freq_setting.code == $past(soft_reg))
		else $error("soft code not used");
endmodule : fsw_freq_ctrl_props

bind fsw_freq_ctrl fsw_freq_ctrl_props #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_props (
	.clk(clk), .srst(srst), .reg_wr(reg_wr), .sys_rst_oe_n(sys_rst_oe_n),
	.freq_setting(freq_setting), .freq_load(freq_load), .recovery_mode(recovery_mode));

// ===== bench/fsw_host_model.sv
/*
 smbus host seen as byte writes into the control block.
 assumes the slave engine turns each byte into a one-cycle write pulse.
*/
`timescale 1ns/1ps
module fsw_host_model (
	input wire logic clk,
	output fsw_pkg::fsw_wr_t bus
);
	initial bus = '0;

	////////////////////////////////////////////////////////////////////////
	// released lines flip so stale data never looks like a write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{1'b1, a, d};
		@(posedge clk);
		bus <= '{1'b0, ~a, ~d};
	endtask : wr
	// multiplier then divider in one word write, no idle cycle between
	task automatic wr2(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		bus <= '{1'b1, a, d};
		@(posedge clk);
		bus <= '{1'b1, a + 8'h01, e};
		@(posedge clk);
		bus <= '{1'b0, ~a, ~e};
	endtask : wr2
endmodule : fsw_host_model

// ===== bench/fsw_freq_ctrl_bench.sv
/*
 self-checking bench for the frequency select / watchdog recovery block.
 assumes short watchdog units so an expiry takes tens of cycles.
*/
`timescale 1ns/1ps
module fsw_freq_ctrl_bench;
	logic clk;
	logic srst;
	fsw_pkg::fsw_wr_t reg_wr;
	logic [7:0] reg_rd_addr;
	logic [7:0] reg_rdata;
	logic [4:0] strap_freq_code;
	logic sys_rst_out;
	logic sys_rst_oe_n;
	fsw_pkg::fsw_setting_t freq_setting;
	fsw_pkg::fsw_setting_t held;
	fsw_pkg::fsw_pair_t freq_table_out;
	logic freq_load;
	logic recovery_mode;
	int failures;
	int tests_run;
	logic [7:0] n, m, d;
	logic [4:0] k;
	int cpu_tab [32] = '{2000, 1900, 1800, 1700, 1660, 1600, 1500, 1450, 1400, 1360, 1300,
		1240, 672, 1008, 1180, 1344, 670, 1005, 1150, 1340, 668, 1002, 1100, 1336, 1050, 900,
		850, 780, 666, 1000, 750, 1333};
	int pci_tab [32] = '{333, 380, 360, 340, 332, 320, 375, 363, 350, 340, 325, 310, 336, 336,
		393, 336, 335, 335, 383, 335, 334, 334, 367, 334, 350, 300, 283, 390, 333, 333, 375, 333};

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	fsw_host_model host (.clk(clk), .bus(reg_wr));
	// open-drain reset pin with pull-up, read back by the block
	fsw_freq_ctrl #(.UNIT_SHORT_CYC(20), .UNIT_LONG_CYC(50), .RST_PULSE_CYC(6)) dut (
		.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
		.reg_rdata(reg_rdata), .strap_freq_code(strap_freq_code),
		.sys_rst_in(sys_rst_oe_n | sys_rst_out), .sys_rst_out(sys_rst_out),
		.sys_rst_oe_n(sys_rst_oe_n), .freq_setting(freq_setting),
		.freq_table_out(freq_table_out), .freq_load(freq_load), .recovery_mode(recovery_mode));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] exp_pair(input logic [4:0] c);
		return {12'(cpu_tab[c]), 12'(pci_tab[c])};
	endfunction : exp_pair
	task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_out
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		chk_out({16'h0000, got}, {16'h0000, exp});
	endtask : chk_byte
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd_addr <= a;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask : rd
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task automatic give_verdict();
		$display("tests_run %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// bounded wait for the lock to change
	task automatic wait_rec(input logic v);
		for (int i = 0; i < 300 && recovery_mode !== v; i++)
		begin
			@(posedge clk);
			#1;
		end
		if (recovery_mode !== v)
		begin
			failures++;
			$display("[ERR] %0t watchdog wait ran out", $time);
			give_verdict();
		end
	endtask : wait_rec

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		failures = 0;
		tests_run = 0;
		srst = 1'b1;
		reg_rd_addr = 8'h00;
		strap_freq_code = 5'h00;
		void'($urandom(98179));
		@(posedge clk);
		strap_freq_code <= 5'($urandom);
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (8) @(posedge clk);
		// reset values, reserved and unmapped bytes
		foreach (cpu_tab[i])
		begin
			if (i < 9)
			begin
				rd(i == 8 ? 8'hFF : 8'h0A + 8'(i));
				chk_byte(d, 8'h00);
			end
		end
		rd(8'h15);
		chk_byte(d, 8'h20);
		chk_out(24'({freq_setting.prog, freq_setting.code}), 24'({1'b0, strap_freq_code}));
		$display("test reset done");
		// every soft code, then back to the straps
		for (int c = 0; c < 32; c++)
		begin
			host.wr(fsw_pkg::ADDR_SOFT_CTRL, 8'h20 | 8'(c));
			settle();
			chk_out(freq_table_out, exp_pair(5'(c)));
		end
		host.wr(fsw_pkg::ADDR_SOFT_CTRL, 8'h05);
		settle();
		chk_out(freq_table_out, exp_pair(strap_freq_code));
		$display("test codes done");
		// programmable terms, extreme ratio first
		for (int i = 0; i < 5; i++)
		begin
			m = (i == 0) ? 8'h00 : 8'($urandom % 128);
			n = (i == 0) ? 8'hFF : m + 8'h01 + 8'($urandom % (255 - m));
			k = 5'($urandom);
			host.wr(fsw_pkg::ADDR_SOFT_CTRL, 8'h20 | 8'(k));
			host.wr2(fsw_pkg::ADDR_CPU_MULT, n, 8'h80 | m);
			settle();
			chk_out(freq_setting, {1'b1, k, 9'(n) + 9'h003, 9'(m) + 9'h003});
		end
		$display("test programmable done");
		// watchdog with strap recovery, then with recovery terms
		for (int s = 0; s < 2; s++)
		begin
			n = 8'd100 + 8'($urandom % 100);
			m = 8'($urandom % 60);
			host.wr2(fsw_pkg::ADDR_REC_MULT, n, {s[0], m[6:0]});
			host.wr(fsw_pkg::ADDR_RST_CTRL, {7'h00, s[0]});
			host.wr(fsw_pkg::ADDR_WDOG, 8'h42);
			repeat (150) @(posedge clk);
			chk_byte(8'(recovery_mode), 8'h00);
			host.wr(fsw_pkg::ADDR_SOFT_CTRL, 8'h2B);
			wait_rec(1'b1);
			chk_byte(8'(sys_rst_oe_n), 8'(!s[0]));
			settle();
			chk_out(24'({freq_setting.prog, freq_setting.code}),
				s ? 24'h2B : 24'(strap_freq_code));
			if (s)
				chk_out(18'(freq_setting), {9'(n) + 9'h003, 9'(m) + 9'h003});
			held = freq_setting;
			host.wr2(fsw_pkg::ADDR_CPU_MULT, 8'hFF, 8'h81);
			host.wr(fsw_pkg::ADDR_WDOG, 8'h42);
			settle();
			chk_out(freq_setting, held);
			rd(fsw_pkg::ADDR_WDOG);
			chk_byte(d & 8'hC0, 8'hC0);
			host.wr(fsw_pkg::ADDR_WDOG, 8'h80);
			wait_rec(1'b0);
			rd(fsw_pkg::ADDR_WDOG);
			chk_byte(d & 8'hC0, 8'h00);
		end
		$display("test watchdog done");
		// reset pulse after a frequency change, pin read back low
		host.wr(fsw_pkg::ADDR_RST_CTRL, 8'h02);
		host.wr(fsw_pkg::ADDR_CPU_MULT, 8'hC8);
		#1 chk_byte(8'(sys_rst_oe_n), 8'h00);
		chk_byte(8'(sys_rst_out), 8'h00);
		// pin level passes three flops before it reads back low
		repeat (3) @(posedge clk);
		rd(fsw_pkg::ADDR_RST_CTRL);
		chk_byte(d & 8'h23, 8'h02);
		repeat (10) @(posedge clk);
		#1 chk_byte(8'(sys_rst_oe_n), 8'h01);
		$display("test change reset done");
		give_verdict();
	end
endmodule : fsw_freq_ctrl_bench
